// >>> hdl/dioa_pkg.sv
package dioa_pkg;

    // Bus geometry
    localparam int ADR_W    = 14;
    localparam int DAT_W    = 32;
    localparam int SEL_W    = 4;
    localparam int IDX_W    = 12;
    localparam int REG_W    = 8;

    // Port widths
    localparam int WIDE_W   = 8;
    localparam int NARROW_W = 2;
    localparam int FUNC_W   = 5;

    // Register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_WIDE_LATCH   = 12'h007;
    localparam logic [IDX_W-1:0] IDX_NARROW_LATCH = 12'h008;
    localparam logic [IDX_W-1:0] IDX_WIDE_IN      = 12'h014;
    localparam logic [IDX_W-1:0] IDX_NARROW_IN    = 12'h015;
    localparam logic [IDX_W-1:0] IDX_WIDE_DIR     = 12'hf21;
    localparam logic [IDX_W-1:0] IDX_NARROW_DIR   = 12'hf22;
    localparam logic [IDX_W-1:0] IDX_WIDE_FUNC    = 12'hf3b;
    localparam logic [IDX_W-1:0] IDX_NARROW_FUNC  = 12'hf3c;

    // Byte address field of the word index
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 13;

    // Reset values
    localparam logic [WIDE_W-1:0]   RST_WIDE   = 8'h00;
    localparam logic [NARROW_W-1:0] RST_NARROW = 2'h0;
    localparam logic [FUNC_W-1:0]   RST_FUNC   = 5'h00;
    localparam logic [DAT_W-1:0]    RD_ZERO    = 32'h0000_0000;

    // Wide-port pin positions of the interrupt inputs
    localparam int IRQ_LSB = 5;
    localparam int IRQ_MSB = 7;

endpackage

// >>> hdl/dioa_pin_cell.sv
module dioa_pin_cell (
    // Control
    input  wire logic dir_i,
    input  wire logic func_i,
    input  wire logic latch_i,
    // Peripheral side
    input  wire logic periph_out_i,
    output logic      periph_in_o,
    // Pin side
    input  wire logic pin_sync_i,
    output logic      pin_o,
    output logic      pin_oe_o,
    // Readback
    output logic      read_o
);

    wire drive_periph;

    assign drive_periph = dir_i & func_i;
    // The pin is driven only in output mode
    assign pin_oe_o     = dir_i;
    assign pin_o        = drive_periph ? periph_out_i : latch_i;
    // Peripheral inputs see the pin only in input mode, held low otherwise
    assign periph_in_o  = ~dir_i & pin_sync_i;
    assign read_o       = ~dir_i & pin_sync_i;

endmodule

// >>> hdl/dioa_port.sv
module dioa_port (
    // System
    input  wire logic                        clk_sys_i,
    input  wire logic                        resetn_i,
    // Wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [dioa_pkg::ADR_W-1:0]  wb_adr_i,
    input  wire logic [dioa_pkg::SEL_W-1:0]  wb_sel_i,
    input  wire logic [dioa_pkg::DAT_W-1:0]  wb_dat_i,
    output logic      [dioa_pkg::DAT_W-1:0]  wb_dat_o,
    output logic                             wb_ack_o,
    // Wide port pins
    input  wire logic [dioa_pkg::WIDE_W-1:0] wide_pin_i,
    output logic      [dioa_pkg::WIDE_W-1:0] wide_pin_o,
    output logic      [dioa_pkg::WIDE_W-1:0] wide_pin_oe_o,
    // Narrow port pins
    input  wire logic [dioa_pkg::NARROW_W-1:0] narrow_pin_i,
    output logic      [dioa_pkg::NARROW_W-1:0] narrow_pin_o,
    output logic      [dioa_pkg::NARROW_W-1:0] narrow_pin_oe_o,
    // Peripheral outputs to the pins
    input  wire logic                        divider_out_i,
    input  wire logic                        pulse_gen_hi_out_1_i,
    input  wire logic                        pulse_gen_hi_out_0_i,
    input  wire logic                        pulse_gen_out_0_i,
    input  wire logic                        pulse_gen_out_1_i,
    input  wire logic                        pulse_gen_out_2_i,
    input  wire logic                        pulse_gen_out_3_i,
    input  wire logic                        pwm_out_0_i,
    input  wire logic                        pwm_out_1_i,
    input  wire logic                        pwm_out_2_i,
    input  wire logic                        pwm_out_3_i,
    // Peripheral inputs from the pins
    output logic                             ext_irq_in_c_o,
    output logic                             ext_irq_in_b_o,
    output logic                             ext_irq_in_a_o,
    output logic                             timer_hi_in_1_o,
    output logic                             timer_hi_in_0_o,
    output logic                             timer_in_0_o,
    output logic                             timer_in_1_o,
    output logic                             timer_in_2_o,
    output logic                             timer_in_3_o
);

    localparam int WW = dioa_pkg::WIDE_W;
    localparam int NW = dioa_pkg::NARROW_W;
    localparam int FW = dioa_pkg::FUNC_W;

    // Software-visible state
    logic [WW-1:0] wide_latch;
    logic [WW-1:0] wide_dir;
    logic [FW-1:0] wide_func;
    logic [NW-1:0] narrow_latch;
    logic [NW-1:0] narrow_dir;
    logic [NW-1:0] narrow_func;
    logic          ack;
    logic [dioa_pkg::DAT_W-1:0] rdata;

    // Pin synchronisers
    logic [WW-1:0] wide_meta;
    logic [WW-1:0] wide_sync;
    logic [NW-1:0] narrow_meta;
    logic [NW-1:0] narrow_sync;

    // Bus decode
    wire [dioa_pkg::IDX_W-1:0] word_idx;
    wire                       bus_req;
    wire                       take_req;
    wire                       wr_fire;
    wire hit_wide_latch;
    wire hit_narrow_latch;
    wire hit_wide_in;
    wire hit_narrow_in;
    wire hit_wide_dir;
    wire hit_narrow_dir;
    wire hit_wide_func;
    wire hit_narrow_func;
    wire [dioa_pkg::REG_W-1:0] wr_byte;
    wire [dioa_pkg::REG_W-1:0] read_byte;
    wire [WW-1:0] wide_read;
    wire [NW-1:0] narrow_read;
    wire [WW-1:0] wide_func_full;
    wire [WW-1:0] wide_periph_out;
    wire [WW-1:0] wide_periph_in;
    wire [NW-1:0] narrow_periph_out;
    wire [NW-1:0] narrow_periph_in;

    assign word_idx = wb_adr_i[dioa_pkg::IDX_MSB:dioa_pkg::IDX_LSB];
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign take_req = bus_req & ~ack;
    // Writes land on the edge where the master sees ack, as classic Wishbone expects
    assign wr_fire  = bus_req & wb_we_i & ack & wb_sel_i[0];
    assign wr_byte  = wb_dat_i[dioa_pkg::REG_W-1:0];

    assign hit_wide_latch   = (word_idx == dioa_pkg::IDX_WIDE_LATCH);
    assign hit_narrow_latch = (word_idx == dioa_pkg::IDX_NARROW_LATCH);
    assign hit_wide_in      = (word_idx == dioa_pkg::IDX_WIDE_IN);
    assign hit_narrow_in    = (word_idx == dioa_pkg::IDX_NARROW_IN);
    assign hit_wide_dir     = (word_idx == dioa_pkg::IDX_WIDE_DIR);
    assign hit_narrow_dir   = (word_idx == dioa_pkg::IDX_NARROW_DIR);
    assign hit_wide_func    = (word_idx == dioa_pkg::IDX_WIDE_FUNC);
    assign hit_narrow_func  = (word_idx == dioa_pkg::IDX_NARROW_FUNC);

    // Unmapped words and reserved bits read as zero
    assign read_byte =
        hit_wide_latch   ? wide_latch :
        hit_narrow_latch ? {6'h00, narrow_latch} :
        hit_wide_in      ? wide_read :
        hit_narrow_in    ? {6'h00, narrow_read} :
        hit_wide_dir     ? wide_dir :
        hit_narrow_dir   ? {6'h00, narrow_dir} :
        hit_wide_func    ? wide_func_full :
        hit_narrow_func  ? {6'h00, narrow_func} : 8'h00;

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack   <= 1'b0;
            rdata <= dioa_pkg::RD_ZERO;
        end else begin
            ack <= take_req;
            if (take_req) begin
                rdata <= {24'h00_0000, read_byte};
            end
        end
    end

    // Upper bits of the narrow and wide-function registers do not exist
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wide_latch   <= dioa_pkg::RST_WIDE;
            wide_dir     <= dioa_pkg::RST_WIDE;
            wide_func    <= dioa_pkg::RST_FUNC;
            narrow_latch <= dioa_pkg::RST_NARROW;
            narrow_dir   <= dioa_pkg::RST_NARROW;
            narrow_func  <= dioa_pkg::RST_NARROW;
        end else if (wr_fire) begin
            if (hit_wide_latch)   wide_latch   <= wr_byte;
            if (hit_wide_dir)     wide_dir     <= wr_byte;
            if (hit_wide_func)    wide_func    <= wr_byte[FW-1:0];
            if (hit_narrow_latch) narrow_latch <= wr_byte[NW-1:0];
            if (hit_narrow_dir)   narrow_dir   <= wr_byte[NW-1:0];
            if (hit_narrow_func)  narrow_func  <= wr_byte[NW-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wide_meta   <= dioa_pkg::RST_WIDE;
            wide_sync   <= dioa_pkg::RST_WIDE;
            narrow_meta <= dioa_pkg::RST_NARROW;
            narrow_sync <= dioa_pkg::RST_NARROW;
        end else begin
            wide_meta   <= wide_pin_i;
            wide_sync   <= wide_meta;
            narrow_meta <= narrow_pin_i;
            narrow_sync <= narrow_meta;
        end
    end

    // Bits 7-5 have no alternate output, so they always use the latch
    assign wide_func_full = {3'h0, wide_func};
    // Timer outputs: the idle one of pulse and PWM is expected to sit low
    assign wide_periph_out = {3'h0, divider_out_i, pulse_gen_hi_out_1_i, pulse_gen_hi_out_0_i,
                              pulse_gen_out_1_i | pwm_out_1_i, pulse_gen_out_0_i | pwm_out_0_i};
    assign narrow_periph_out = {pulse_gen_out_3_i | pwm_out_3_i, pulse_gen_out_2_i | pwm_out_2_i};

    genvar gi;
    generate
        for (gi = 0; gi < WW; gi++) begin : g_wide
            dioa_pin_cell u_cell (
                .dir_i        (wide_dir[gi]),
                .func_i       (wide_func_full[gi]),
                .latch_i      (wide_latch[gi]),
                .periph_out_i (wide_periph_out[gi]),
                .periph_in_o  (wide_periph_in[gi]),
                .pin_sync_i   (wide_sync[gi]),
                .pin_o        (wide_pin_o[gi]),
                .pin_oe_o     (wide_pin_oe_o[gi]),
                .read_o       (wide_read[gi])
            );
        end
        for (gi = 0; gi < NW; gi++) begin : g_narrow
            dioa_pin_cell u_cell (
                .dir_i        (narrow_dir[gi]),
                .func_i       (narrow_func[gi]),
                .latch_i      (narrow_latch[gi]),
                .periph_out_i (narrow_periph_out[gi]),
                .periph_in_o  (narrow_periph_in[gi]),
                .pin_sync_i   (narrow_sync[gi]),
                .pin_o        (narrow_pin_o[gi]),
                .pin_oe_o     (narrow_pin_oe_o[gi]),
                .read_o       (narrow_read[gi])
            );
        end
    endgenerate

    assign ext_irq_in_c_o  = wide_periph_in[7];
    assign ext_irq_in_b_o  = wide_periph_in[6];
    assign ext_irq_in_a_o  = wide_periph_in[5];
    assign timer_hi_in_1_o = wide_periph_in[3];
    assign timer_hi_in_0_o = wide_periph_in[2];
    assign timer_in_1_o    = wide_periph_in[1];
    assign timer_in_0_o    = wide_periph_in[0];
    assign timer_in_3_o    = narrow_periph_in[1];
    assign timer_in_2_o    = narrow_periph_in[0];

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    property p_wide_oe;
        wide_pin_oe_o == wide_dir && narrow_pin_oe_o == narrow_dir;
    endproperty
    a_wide_oe: assert property (p_wide_oe) else $error("pin enable differs from direction");

    property p_latch_drive;
        (wide_dir[6] && !wide_func_full[6]) |-> wide_pin_o[6] == wide_latch[6];
    endproperty
    a_latch_drive: assert property (p_latch_drive) else $error("output pin not at latch");

    property p_func_high_zero;
        take_req && hit_wide_func |=> wb_ack_o && wb_dat_o[7:5] == 3'h0;
    endproperty
    a_func_high_zero: assert property (p_func_high_zero) else $error("function bits 7-5 not zero");

    property p_wide_in_read;
        take_req && hit_wide_in && !wb_we_i |=> (wb_dat_o[7:0] & $past(wide_dir)) == 8'h00;
    endproperty
    a_wide_in_read: assert property (p_wide_in_read) else $error("output bit read nonzero");

    property p_narrow_in_read;
        take_req && hit_narrow_in && !wb_we_i |=>
            wb_dat_o[7:0] == {6'h00, ~$past(narrow_dir) & $past(narrow_sync)};
    endproperty
    a_narrow_in_read: assert property (p_narrow_in_read) else $error("narrow input read wrong");

    property p_narrow_periph;
        (narrow_dir[0] && narrow_func[0]) |-> narrow_pin_o[0] == (pulse_gen_out_2_i | pwm_out_2_i);
    endproperty
    a_narrow_periph: assert property (p_narrow_periph) else $error("narrow pin not at timer");

    property p_irq_feed;
        !wide_dir[7] && $stable(wide_pin_i[7]) [*3] |-> ext_irq_in_c_o == wide_pin_i[7];
    endproperty
    a_irq_feed: assert property (p_irq_feed) else $error("interrupt input not following pin");

    property p_latch_write;
        wr_fire && hit_narrow_latch |=> narrow_latch == $past(wb_dat_i[1:0]) && !wb_ack_o;
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("narrow latch write lost");

    property p_dir_read_high;
        take_req && hit_narrow_dir |=> wb_dat_o[31:2] == 30'h0000_0000;
    endproperty
    a_dir_read_high: assert property (p_dir_read_high) else $error("reserved bits nonzero");

    property p_wide_periph;
        (wide_dir[4] && wide_func[4]) |-> wide_pin_o[4] == divider_out_i;
    endproperty
    a_wide_periph: assert property (p_wide_periph) else $error("divider output not on pin");

    property p_narrow_latch_drive;
        (narrow_dir[1] && !narrow_func[1]) |-> narrow_pin_o[1] == narrow_latch[1];
    endproperty
    a_narrow_latch_drive: assert property (p_narrow_latch_drive) else $error("narrow pin not at latch");

    property p_irq_out_mode;
        wide_dir[7] |-> !ext_irq_in_c_o;
    endproperty
    a_irq_out_mode: assert property (p_irq_out_mode) else $error("interrupt input active in output mode");

    property p_wide_in_value;
        take_req && hit_wide_in |=> wb_dat_o[7:0] == (~$past(wide_dir) & $past(wide_sync));
    endproperty
    a_wide_in_value: assert property (p_wide_in_value) else $error("wide input read wrong");

    property p_narrow_func_write;
        wr_fire && hit_narrow_func |=> narrow_func == $past(wb_dat_i[1:0]);
    endproperty
    a_narrow_func_write: assert property (p_narrow_func_write) else $error("narrow function write lost");

    property p_timer_feed;
        !wide_dir[0] |-> timer_in_0_o == wide_sync[0];
    endproperty
    a_timer_feed: assert property (p_timer_feed) else $error("timer input not following pin");

    c_wide_func_on:  cover property (wr_fire && hit_wide_func && wr_byte[4]);
    c_irq_seen:      cover property (ext_irq_in_c_o && !wide_dir[7]);
    c_narrow_out:    cover property (narrow_dir == 2'h3 && narrow_func == 2'h1);
    c_input_read:    cover property (take_req && hit_wide_in && wide_dir == 8'h0f);

endmodule

// >>> tb/dioa_pins_model.sv
// External circuitry on both ports: a weak source per pin that loses to the port driver
module dioa_pins_model (
    // Levels the outside world tries to put on the pins
    input  wire logic [7:0] ext_wide_i,
    input  wire logic [1:0] ext_narrow_i,
    // Port drivers
    input  wire logic [7:0] wide_pin_o_i,
    input  wire logic [7:0] wide_oe_i,
    input  wire logic [1:0] narrow_pin_o_i,
    input  wire logic [1:0] narrow_oe_i,
    // Resolved wire levels
    output logic      [7:0] wide_wire_o,
    output logic      [1:0] narrow_wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin shows the port level, otherwise the external source wins
    assign wide_wire_o   = (wide_oe_i & wide_pin_o_i) | (~wide_oe_i & ext_wide_i);
    assign narrow_wire_o = (narrow_oe_i & narrow_pin_o_i) | (~narrow_oe_i & ext_narrow_i);
endmodule

// >>> tb/tb_dioa_port.sv
module tb_dioa_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i;
    logic        resetn_i;
    logic        cyc, stb, we;
    logic [13:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rsink;
    logic        ack;
    logic [7:0]  wpin_i, wpin_o, woe, ext_w;
    logic [1:0]  npin_i, npin_o, noe, ext_n;
    logic [10:0] per;
    logic [8:0]  pins_seen;
    logic [7:0]  exp_w;
    logic [1:0]  exp_n;
    int          error_cnt, checks_done, k;
    localparam logic [11:0] RW_IDX [0:5] = '{dioa_pkg::IDX_WIDE_LATCH, dioa_pkg::IDX_NARROW_LATCH,
        dioa_pkg::IDX_WIDE_DIR, dioa_pkg::IDX_NARROW_DIR, dioa_pkg::IDX_WIDE_FUNC, dioa_pkg::IDX_NARROW_FUNC};
    localparam logic [31:0] RW_MASK [0:5] = '{32'h0000_00FF, 32'h0000_0003, 32'h0000_00FF,
        32'h0000_0003, 32'h0000_001F, 32'h0000_0003};

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    dioa_pins_model dioa_pins_model_inst (.ext_wide_i(ext_w), .ext_narrow_i(ext_n), .wide_pin_o_i(wpin_o),
        .wide_oe_i(woe), .narrow_pin_o_i(npin_o), .narrow_oe_i(noe), .wide_wire_o(wpin_i), .narrow_wire_o(npin_i));

    dioa_port dioa_port_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wide_pin_i(wpin_i), .wide_pin_o(wpin_o), .wide_pin_oe_o(woe), .narrow_pin_i(npin_i),
        .narrow_pin_o(npin_o), .narrow_pin_oe_o(noe), .divider_out_i(per[0]), .pulse_gen_hi_out_0_i(per[1]),
        .pulse_gen_hi_out_1_i(per[2]), .pulse_gen_out_0_i(per[3]), .pulse_gen_out_1_i(per[4]),
        .pulse_gen_out_2_i(per[5]), .pulse_gen_out_3_i(per[6]), .pwm_out_0_i(per[7]), .pwm_out_1_i(per[8]),
        .pwm_out_2_i(per[9]), .pwm_out_3_i(per[10]), .ext_irq_in_c_o(pins_seen[8]), .ext_irq_in_b_o(pins_seen[7]),
        .ext_irq_in_a_o(pins_seen[6]), .timer_hi_in_1_o(pins_seen[5]), .timer_hi_in_0_o(pins_seen[4]),
        .timer_in_1_o(pins_seen[3]), .timer_in_0_o(pins_seen[2]), .timer_in_3_o(pins_seen[1]),
        .timer_in_2_o(pins_seen[0]));

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // One classic cycle; the answer is waited for, never assumed
    task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
        int n;
        @(posedge clk_sys_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= s; wdat <= d;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            $display("[ERR] bus ack expected 1 seen timeout");
            close_out();
        end
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, idx, d, 4'hF, r);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, idx, 32'h0000_0000, 4'hF, r);
        check(name, r, exp);
    endtask

    initial begin
        resetn_i = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; wdat = '0;
        ext_w = 8'h5A; ext_n = 2'h2; per = '0; error_cnt = 0; checks_done = 0;
        ticks(12);
        resetn_i <= 1'b1;
        ticks(3);
        for (k = 0; k < 6; k++) rd_chk("reset value", RW_IDX[k], 32'h0000_0000);
        check("wide oe", {24'h0, woe}, 32'h0000_0000);
        check("narrow oe", {30'h0, noe}, 32'h0000_0000);
        rd_chk("wide in", dioa_pkg::IDX_WIDE_IN, 32'h0000_005A);
        rd_chk("narrow in", dioa_pkg::IDX_NARROW_IN, 32'h0000_0002);
        $display("Test reset values done");

        for (k = 0; k < 6; k++) wr(RW_IDX[k], 32'hFFFF_FFFF);
        wr(dioa_pkg::IDX_WIDE_IN, 32'hFFFF_FFFF);
        wr(dioa_pkg::IDX_NARROW_IN, 32'hFFFF_FFFF);
        wb(1'b1, dioa_pkg::IDX_WIDE_LATCH, 32'h0000_0000, 4'h0, rsink);
        for (k = 0; k < 6; k++) rd_chk("writable bits", RW_IDX[k], RW_MASK[k]);
        rd_chk("wide in output mode", dioa_pkg::IDX_WIDE_IN, 32'h0000_0000);
        rd_chk("narrow in output mode", dioa_pkg::IDX_NARROW_IN, 32'h0000_0000);
        rd_chk("unmapped word", 12'h100, 32'h0000_0000);
        $display("Test register access done");

        wr(dioa_pkg::IDX_WIDE_FUNC, 32'h0000_0000);
        wr(dioa_pkg::IDX_NARROW_FUNC, 32'h0000_0000);
        wr(dioa_pkg::IDX_WIDE_LATCH, 32'h0000_00A5);
        wr(dioa_pkg::IDX_NARROW_LATCH, 32'h0000_0001);
        ticks(2);
        check("wide pins", {24'h0, wpin_o}, 32'h0000_00A5);
        check("wide oe", {24'h0, woe}, 32'h0000_00FF);
        check("narrow pins", {30'h0, npin_o}, 32'h0000_0001);
        check("periph inputs output mode", {23'h0, pins_seen}, 32'h0000_0000);
        wr(dioa_pkg::IDX_WIDE_DIR, 32'h0000_000F);
        ticks(3);
        check("wide oe mixed", {24'h0, woe}, 32'h0000_000F);
        check("wide pins mixed", {28'h0, wpin_o[3:0]}, 32'h0000_0005);
        rd_chk("wide in mixed", dioa_pkg::IDX_WIDE_IN, 32'h0000_0050);
        $display("Test latch drive done");

        wr(dioa_pkg::IDX_WIDE_DIR, 32'h0000_00FF);
        wr(dioa_pkg::IDX_WIDE_FUNC, 32'h0000_001F);
        wr(dioa_pkg::IDX_NARROW_FUNC, 32'h0000_0003);
        for (k = 0; k < 11; k++) begin
            per <= 11'h001 << k;
            ticks(2);
            exp_w = {3'b101, per[0], per[2], per[1], per[4] | per[8], per[3] | per[7]};
            exp_n = {per[6] | per[10], per[5] | per[9]};
            check("wide peripheral route", {24'h0, wpin_o}, {24'h0, exp_w});
            check("narrow peripheral route", {30'h0, npin_o}, {30'h0, exp_n});
        end
        // Bit 0 on the timer, bit 1 back on its latch: each must differ from the other source
        wr(dioa_pkg::IDX_NARROW_FUNC, 32'h0000_0001);
        per <= 11'h400;
        ticks(2);
        check("narrow mixed route", {30'h0, npin_o}, 32'h0000_0000);
        per <= '0;
        $display("Test function select done");

        wr(dioa_pkg::IDX_WIDE_DIR, 32'h0000_0000);
        wr(dioa_pkg::IDX_NARROW_DIR, 32'h0000_0000);
        for (k = 0; k < 2; k++) begin
            ext_w <= (k == 0) ? 8'hAC : 8'h53;
            ext_n <= (k == 0) ? 2'h1 : 2'h2;
            ticks(3);
            check("periph inputs", {23'h0, pins_seen},
                  {23'h0, ext_w[7:5], ext_w[3:0], ext_n});
            rd_chk("wide in pattern", dioa_pkg::IDX_WIDE_IN, {24'h0, ext_w});
            rd_chk("narrow in pattern", dioa_pkg::IDX_NARROW_IN, {30'h0, ext_n});
        end
        $display("Test input mode done");
        close_out();
    end
endmodule
